/* File: src/rate_status_pkg.sv */
/*
  package for the rate configuration and result status block: offsets, field
  positions, reset values, codes and carrier structs.
  assumes nothing beyond a SystemVerilog-2012 compiler.
*/
`default_nettype none
package rate_status_pkg;

  localparam logic [9:0] RATE_CONFIG_CONTROL_ADDR = 10'h3F7;
  localparam int RATE_FIELD_LSB = 0;
  localparam int PRECOMP_BIT = 2;
  localparam logic [1:0] RATE_RESET_VALUE = 2'h2;
  localparam logic PRECOMP_RESET_VALUE = 1'h0;
  localparam logic DENSITY_RESET_VALUE = 1'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam int RECAL_STEP_LIMIT = 80;

  typedef enum logic [1:0] {
    MODE_AT = 2'h0,
    MODE_PS2 = 2'h1,
    MODE_M30 = 2'h3
  } reg_mode_t;

  typedef enum logic [1:0] {
    TERM_NORMAL = 2'h0,
    TERM_ABNORMAL = 2'h1,
    TERM_INVALID = 2'h2,
    TERM_POLLING = 2'h3
  } term_code_t;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'h0,
    CMD_BUSY = 2'h1,
    CMD_DONE = 2'h3
  } cmd_state_t;

  // one-cycle event strobes from the command engine
  typedef struct packed {
    logic seekDone;
    logic recalStep;
    logic relSeekPastZero;
    logic sectorPastEnd;
    logic dataCmdEnd;
    logic crcFail;
    logic serviceLate;
    logic sectorMissing;
    logic idUnreadable;
    logic trackOrderBad;
    logic writeCmd;
    logic noIdMark;
    logic noDataMark;
  } cmd_events_t;

  typedef struct packed {
    logic endOfTrack;
    logic crcError;
    logic overrun;
    logic sectorNotFound;
    logic writeProtected;
    logic missingMark;
  } st1_flags_t;

endpackage
`default_nettype wire

/* File: src/rate_config_reg.sv */
/*
  rate configuration control register: data rate field and precompensation
  disable flag, plus the density select output.
  assumes writes are qualified one-cycle strobes from the host decoder.
*/
`timescale 1ns/1ps
`default_nettype none
module rate_config_reg
  import rate_status_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic writeStrobe,
  input wire logic [7:0] writeData,
  input wire reg_mode_t regMode,
  output logic [1:0] rateSelect,
  output logic precompDisable,
  output logic densitySelect
);

  typedef struct packed {
    logic [1:0] rate;
    logic precomp;
    logic density;
  } cfg_state_t;

  cfg_state_t state;
  cfg_state_t next_state;

  // software resets are not wired in: nothing here may react to them
  always_comb begin
    next_state = state;
    if (writeStrobe) begin
      next_state.rate = writeData[RATE_FIELD_LSB +: 2];
      if (regMode == MODE_M30) begin
        next_state.precomp = writeData[PRECOMP_BIT];
      end
    end
    // density follows the rate, high for the slow rates
    next_state.density = (next_state.rate == RATE_250K) || (next_state.rate == RATE_300K);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{RATE_RESET_VALUE, PRECOMP_RESET_VALUE, DENSITY_RESET_VALUE};
    end else begin
      state <= next_state;
    end
  end

  assign rateSelect = state.rate;
  assign precompDisable = state.precomp;
  assign densitySelect = state.density;

  a_rate_write: assert property (@(posedge clock) disable iff (!reset_n)
    writeStrobe |=> rateSelect == $past(writeData[1:0]))
    else $error("rate field did not take written value");
  a_precomp_mode: assert property (@(posedge clock) disable iff (!reset_n)
    writeStrobe && regMode != MODE_M30 |=> $stable(precompDisable))
    else $error("precomp flag changed outside third mode");

endmodule
`default_nettype wire

/* File: src/recal_step_counter.sv */
/*
  counts step pulses of a recalibrate and flags a fault when track zero is
  not reached within the step limit.
  assumes start is a one-cycle pulse at the start of each command.
*/
`timescale 1ns/1ps
`default_nettype none
module recal_step_counter
  import rate_status_pkg::*;
#(
  parameter int STEP_LIMIT = RECAL_STEP_LIMIT
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic start,
  input wire logic stepPulse,
  input wire logic trackZero,
  output logic fault
);

  initial begin
    if (STEP_LIMIT < 1 || STEP_LIMIT > 255) $error("STEP_LIMIT out of range");
  end

  typedef struct packed {
    logic [7:0] count;
    logic fault;
  } step_state_t;

  step_state_t state;
  step_state_t next_state;

  always_comb begin
    next_state = state;
    if (start) begin
      next_state = '0;
    end else if (stepPulse && !trackZero) begin
      if (state.count == 8'(STEP_LIMIT - 1)) begin
        next_state.fault = 1'b1;
      end else begin
        next_state.count = state.count + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign fault = state.fault;

endmodule
`default_nettype wire

/* File: src/rate_result_status.sv */
/*
  top of the rate configuration and result status block: decodes the host
  write to the rate configuration control address, forms the rate status
  byte and the first two result status bytes.
  assumes the command engine supplies one-cycle event strobes, the current
  head and drive, and a start pulse for each new command.
*/
`timescale 1ns/1ps
`default_nettype none
module rate_result_status
  import rate_status_pkg::*;
#(
  parameter int STEP_LIMIT = RECAL_STEP_LIMIT
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic softReset,
  input wire logic [9:0] hostAddr,
  input wire logic hostWrite,
  input wire logic [7:0] hostWriteData,
  input wire reg_mode_t regMode,
  input wire logic cmdStart,
  input wire logic cmdFinish,
  input wire term_code_t termCode,
  input wire cmd_events_t events,
  input wire logic headNumber,
  input wire logic [1:0] driveNumber,
  input wire logic trackZeroInput,
  input wire logic writeProtectInput,
  input wire logic terminalCountInput,
  output logic [1:0] rateSelect,
  output logic precompDisable,
  output logic densitySelectOutput,
  output logic [7:0] rateStatus,
  output logic [7:0] resultStatusZero,
  output logic [7:0] resultStatusOne,
  output logic resultValid
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic hitAddr(input logic [9:0] addr, input logic [9:0] target);
    hitAddr = (addr == target);
  endfunction

  logic cfgWrite;
  logic [1:0] cfgRate;
  logic cfgPrecomp;
  logic cfgDensity;
  logic recalFault;

  assign cfgWrite = hostWrite && hitAddr(hostAddr, RATE_CONFIG_CONTROL_ADDR);

  // upper data bits are assumed zero from the host and are simply dropped
  rate_config_reg u_cfg (
    .clock(clock),
    .reset_n(reset_n),
    .writeStrobe(cfgWrite),
    .writeData(hostWriteData),
    .regMode(regMode),
    .rateSelect(cfgRate),
    .precompDisable(cfgPrecomp),
    .densitySelect(cfgDensity)
  );

  recal_step_counter #(
    .STEP_LIMIT(STEP_LIMIT)
  ) u_steps (
    .clock(clock),
    .reset_n(reset_n),
    .start(cmdStart),
    .stepPulse(events.recalStep),
    .trackZero(trackZeroInput),
    .fault(recalFault)
  );

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    cmd_state_t cmd;
    logic seekEnd;
    logic equipFault;
    st1_flags_t flags;
    logic [7:0] statusZero;
    logic [7:0] statusOne;
    logic valid;
    logic [7:0] rateByte;
    logic [1:0] rateOut;
    logic precompOut;
    logic densityOut;
    logic wpPrev;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.wpPrev = writeProtectInput;
    // mirrors of the config register, one flop deep so outputs stay registered
    next_state.rateOut = cfgRate;
    next_state.precompOut = cfgPrecomp;
    next_state.densityOut = cfgDensity;
    next_state.rateByte = 8'h00;
    next_state.rateByte[1:0] = cfgRate;
    if (regMode == MODE_M30) begin
      next_state.rateByte[PRECOMP_BIT] = cfgPrecomp;
    end
    unique case (state.cmd)
      CMD_IDLE, CMD_DONE: begin
        if (cmdStart) begin
          next_state.cmd = CMD_BUSY;
          next_state.seekEnd = 1'b0;
          next_state.equipFault = 1'b0;
          next_state.flags = '0;
          next_state.valid = 1'b0;
        end
      end
      CMD_BUSY: begin
        if (events.seekDone) next_state.seekEnd = 1'b1;
        if (events.relSeekPastZero) next_state.equipFault = 1'b1;
        if (events.sectorPastEnd) next_state.flags.endOfTrack = 1'b1;
        if (events.dataCmdEnd && !terminalCountInput) begin
          next_state.flags.endOfTrack = 1'b1;
        end
        if (events.crcFail) next_state.flags.crcError = 1'b1;
        if (events.serviceLate) next_state.flags.overrun = 1'b1;
        if (events.sectorMissing || events.idUnreadable || events.trackOrderBad) begin
          next_state.flags.sectorNotFound = 1'b1;
        end
        if (events.writeCmd && writeProtectInput && !state.wpPrev) begin
          next_state.flags.writeProtected = 1'b1;
        end
        if (events.noIdMark || events.noDataMark) begin
          next_state.flags.missingMark = 1'b1;
        end
        if (cmdFinish) begin
          next_state.cmd = CMD_DONE;
          next_state.valid = 1'b1;
          next_state.statusZero = {termCode, next_state.seekEnd,
            next_state.equipFault | recalFault, 1'b0, headNumber, driveNumber};
          next_state.statusOne = {next_state.flags.endOfTrack, 1'b0,
            next_state.flags.crcError, next_state.flags.overrun, 1'b0,
            next_state.flags.sectorNotFound, next_state.flags.writeProtected,
            next_state.flags.missingMark};
        end
      end
      default: begin
        next_state.cmd = CMD_IDLE;
      end
    endcase
    // software reset aborts the command but never touches rate or density
    if (softReset) begin
      next_state.cmd = CMD_IDLE;
      next_state.valid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{cmd: CMD_IDLE, seekEnd: 1'b0, equipFault: 1'b0, flags: '0,
        statusZero: 8'h00, statusOne: 8'h00, valid: 1'b0, rateByte: 8'h02,
        rateOut: RATE_RESET_VALUE, precompOut: PRECOMP_RESET_VALUE,
        densityOut: DENSITY_RESET_VALUE, wpPrev: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign rateSelect = state.rateOut;
  assign precompDisable = state.precompOut;
  assign densitySelectOutput = state.densityOut;
  assign rateStatus = state.rateByte;
  assign resultStatusZero = state.statusZero;
  assign resultStatusOne = state.statusOne;
  assign resultValid = state.valid;

  ////////////////////////////////////////////////////////////////////////////

  a_zero_unused: assert property (@(posedge clock) disable iff (!reset_n)
    resultStatusZero[3] == 1'b0 && resultStatusOne[6] == 1'b0
      && resultStatusOne[3] == 1'b0)
    else $error("unused status bit is set");
  a_term_code: assert property (@(posedge clock) disable iff (!reset_n)
    state.cmd == CMD_BUSY && cmdFinish && !softReset |=> resultStatusZero[7:6] == $past(termCode))
    else $error("termination code mismatch");
  a_head_drive: assert property (@(posedge clock) disable iff (!reset_n)
    state.cmd == CMD_BUSY && cmdFinish && !softReset
      |=> resultStatusZero[2:0] == $past({headNumber, driveNumber}))
    else $error("head or drive mismatch");
  a_crc_flag: assert property (@(posedge clock) disable iff (!reset_n)
    state.cmd == CMD_BUSY && events.crcFail && !cmdStart && !softReset
      ##1 (state.cmd == CMD_BUSY && cmdFinish && !softReset) |=> resultStatusOne[5])
    else $error("crc error flag lost");
  a_eot_no_tc: assert property (@(posedge clock) disable iff (!reset_n)
    state.cmd == CMD_BUSY && events.dataCmdEnd && !terminalCountInput && cmdFinish
      && !softReset |=> resultStatusOne[7])
    else $error("end of track not set without terminal count");
  a_clear_start: assert property (@(posedge clock) disable iff (!reset_n)
    state.cmd != CMD_BUSY && cmdStart && !softReset |=> state.flags == '0 && !resultValid)
    else $error("flags not cleared at command start");
  a_precomp_read: assert property (@(posedge clock) disable iff (!reset_n)
    regMode == MODE_M30 ##1 regMode == MODE_M30 |-> rateStatus[2] == $past(cfgPrecomp))
    else $error("precomp readback wrong");
  a_soft_keep: assert property (@(posedge clock) disable iff (!reset_n)
    softReset && !cfgWrite ##1 !cfgWrite |=> $stable(rateSelect) && $stable(densitySelectOutput))
    else $error("soft reset disturbed rate or density");
  a_seek_flag: assert property (@(posedge clock) disable iff (!reset_n)
    state.cmd == CMD_BUSY && events.seekDone && cmdFinish && !softReset
      |=> resultStatusZero[5])
    else $error("seek end flag missing");

endmodule
`default_nettype wire

/* File: testbench/host_model.sv */
/*
  host side model: writes the rate configuration control register.
  assumes the block samples the write on a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model
  import rate_status_pkg::*;
(
  input wire logic clock,
  input wire reg_mode_t regMode,
  output logic [9:0] hostAddr,
  output logic hostWrite,
  output logic [7:0] hostWriteData
);
  initial begin
    hostAddr = 10'h000;
    hostWrite = 1'b0;
    hostWriteData = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // reserved bits go out as zero; only the third mode owns bit 2
  task automatic writeConfig(input logic [9:0] addr, input logic [7:0] data);
    @(negedge clock);
    hostAddr = addr;
    hostWriteData = data & ((regMode == MODE_M30) ? 8'h07 : 8'h03);
    hostWrite = 1'b1;
    @(negedge clock);
    hostWrite = 1'b0;
    hostAddr = 10'h000;
    // stale data is inverted so a late sample cannot pass by luck
    hostWriteData = ~hostWriteData;
  endtask
endmodule
`default_nettype wire

/* File: testbench/rate_result_status_tb_top.sv */
/*
  self-checking bench for the rate configuration and result status block.
  assumes the host model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rate_result_status_tb_top
  import rate_status_pkg::*;
;
  localparam int STEP_LIMIT = 3;
  logic clock, reset_n, softReset, cmdStart, cmdFinish, headNumber, hostWrite;
  logic trackZeroInput, writeProtectInput, terminalCountInput;
  logic precompDisable, densitySelectOutput, resultValid;
  logic [9:0] hostAddr;
  logic [7:0] hostWriteData, rateStatus, resultStatusZero, resultStatusOne;
  logic [1:0] driveNumber, rateSelect;
  reg_mode_t regMode;
  term_code_t termCode;
  cmd_events_t events;
  int fails = 0;
  int samplesChecked = 0;

  host_model host (.clock(clock), .regMode(regMode), .hostAddr(hostAddr),
    .hostWrite(hostWrite), .hostWriteData(hostWriteData));

  rate_result_status #(.STEP_LIMIT(STEP_LIMIT)) dut (.clock(clock), .reset_n(reset_n),
    .softReset(softReset), .hostAddr(hostAddr), .hostWrite(hostWrite),
    .hostWriteData(hostWriteData), .regMode(regMode), .cmdStart(cmdStart),
    .cmdFinish(cmdFinish), .termCode(termCode), .events(events), .headNumber(headNumber),
    .driveNumber(driveNumber), .trackZeroInput(trackZeroInput),
    .writeProtectInput(writeProtectInput), .terminalCountInput(terminalCountInput),
    .rateSelect(rateSelect), .precompDisable(precompDisable),
    .densitySelectOutput(densitySelectOutput), .rateStatus(rateStatus),
    .resultStatusZero(resultStatusZero), .resultStatusOne(resultStatusOne),
    .resultValid(resultValid));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (fails == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic pulseSoft();
    @(negedge clock);
    softReset = 1'b1;
    @(negedge clock);
    softReset = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // one command: pulses n times, optional write protect rise, then finish
  task automatic runCmd(input logic [12:0] pulseEv, input logic [12:0] levelEv, input int n,
      input logic wpRise, input logic [1:0] term, input logic [1:0] st0Hi,
      input logic [7:0] expSt1);
    @(negedge clock);
    cmdStart = 1'b1;
    @(negedge clock);
    cmdStart = 1'b0;
    events = cmd_events_t'(levelEv);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      events = cmd_events_t'(levelEv | pulseEv);
      @(negedge clock);
      events = cmd_events_t'(levelEv);
    end
    if (wpRise) begin
      @(negedge clock);
      writeProtectInput = 1'b1;
    end
    @(negedge clock);
    cmdFinish = 1'b1;
    termCode = term_code_t'(term);
    headNumber = term[0];
    driveNumber = ~term;
    @(negedge clock);
    cmdFinish = 1'b0;
    events = '0;
    writeProtectInput = 1'b0;
    for (int k = 0; k < 4 && resultValid !== 1'b1; k++) @(negedge clock);
    checkBit(resultValid, 1'b1);
    checkByte(resultStatusZero, {term, st0Hi, 1'b0, term[0], ~term});
    checkByte(resultStatusOne, expSt1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic testResetValues();
    checkByte({6'h00, rateSelect}, 8'h02);
    checkBit(precompDisable, 1'b0);
    checkBit(densitySelectOutput, 1'b1);
    checkByte(rateStatus, 8'h02);
    checkBit(resultValid, 1'b0);
  endtask

  task automatic testRateWrite();
    host.writeConfig(10'h3F7, 8'h01);
    idle(2);
    checkByte({6'h00, rateSelect}, 8'h01);
    checkByte(rateStatus, 8'h01);
    host.writeConfig(10'h3F5, 8'h03);
    idle(2);
    checkByte({6'h00, rateSelect}, 8'h01);
    host.writeConfig(10'h3F7, 8'h00);
    idle(2);
    checkBit(densitySelectOutput, 1'b0);
    pulseSoft();
    idle(2);
    checkByte({6'h00, rateSelect}, 8'h00);
    checkBit(densitySelectOutput, 1'b0);
    @(negedge clock);
    reset_n = 1'b0;
    @(negedge clock);
    checkByte({6'h00, rateSelect}, 8'h02);
    checkBit(densitySelectOutput, 1'b1);
    reset_n = 1'b1;
    idle(1);
  endtask

  task automatic testPrecomp();
    regMode = MODE_M30;
    host.writeConfig(10'h3F7, 8'h06);
    idle(2);
    checkBit(precompDisable, 1'b1);
    checkByte({6'h00, rateSelect}, 8'h02);
    checkByte(rateStatus, 8'h06);
    pulseSoft();
    idle(2);
    checkByte(rateStatus, 8'h06);
    regMode = MODE_PS2;
    idle(2);
    checkByte(rateStatus, 8'h02);
    regMode = MODE_AT;
  endtask

  // each command shows only its own flag, so leftovers from the last one fail
  task automatic testEventFlags();
    logic [12:0] ev [11] = '{13'h1000, 13'h0400, 13'h0200, 13'h0100, 13'h0080, 13'h0040,
      13'h0020, 13'h0010, 13'h0008, 13'h0002, 13'h0001};
    logic [1:0] hi [11] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    logic [7:0] s1 [11] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h20, 8'h10, 8'h04, 8'h04, 8'h04,
      8'h01, 8'h01};
    for (int i = 0; i < 11; i++) begin
      runCmd(ev[i], 13'h0, 1, 1'b0, i[1:0], hi[i], s1[i]);
    end
  endtask

  task automatic testRecalFault();
    trackZeroInput = 1'b0;
    runCmd(13'h0800, 13'h0, STEP_LIMIT, 1'b0, 2'h1, 2'h1, 8'h00);
    runCmd(13'h0800, 13'h0, STEP_LIMIT - 1, 1'b0, 2'h0, 2'h0, 8'h00);
    trackZeroInput = 1'b1;
    runCmd(13'h0800, 13'h0, STEP_LIMIT, 1'b0, 2'h0, 2'h0, 8'h00);
    trackZeroInput = 1'b0;
  endtask

  task automatic testWriteProtect();
    runCmd(13'h0, 13'h0004, 1, 1'b1, 2'h1, 2'h0, 8'h02);
    runCmd(13'h0, 13'h0, 1, 1'b1, 2'h0, 2'h0, 8'h00);
  endtask

  task automatic testTerminalCount();
    terminalCountInput = 1'b1;
    runCmd(13'h0100, 13'h0, 1, 1'b0, 2'h0, 2'h0, 8'h00);
    terminalCountInput = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    softReset = 1'b0;
    cmdStart = 1'b0;
    cmdFinish = 1'b0;
    headNumber = 1'b0;
    driveNumber = 2'h0;
    trackZeroInput = 1'b0;
    writeProtectInput = 1'b0;
    terminalCountInput = 1'b0;
    regMode = MODE_AT;
    termCode = TERM_NORMAL;
    events = '0;
    idle(10);
    reset_n = 1'b1;
    idle(1);
    testResetValues();
    testRateWrite();
    testPrecomp();
    testEventFlags();
    testRecalFault();
    testWriteProtect();
    testTerminalCount();
    print_verdict();
  end

  // the full run needs well under a thousand cycles
  initial begin
    #(25 * 6000);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
